// file: rtl/twowire_dev_end.sv
// Slave end: memory target and clock/tamper register target.
// Assumes scl, sda and tamper_input are asynchronous to pclk.
`timescale 1ns/1ps
module twowire_dev_end (
	input  wire logic                         pclk,
	input  wire logic                         presetn,
	input  wire logic                         pclk_en,
	twowire_if.device                         link,
	input  wire logic [2:0]                   chip_select_pins,
	input  wire logic                         tamper_input,
	input  wire logic [twowire_pkg::TIME_W-1:0] current_time,
	output logic                              tamper_flag,
	output logic                              timestamp_capture_enable
);
	import twowire_pkg::*;

	// ***********************************************************
	// Input synchronisers and bus conditions
	// ***********************************************************
	logic [1:0]  scl_sy_r;
	logic [1:0]  sda_sy_r;
	logic [1:0]  tin_sy_r;
	logic        scl_q_r;
	logic        sda_q_r;
	logic        tin_q_r;
	logic        scl_s;
	logic        sda_s;
	logic        tin_s;
	logic        start_c;
	logic        stop_c;
	logic        scl_rise;
	logic        scl_fall;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scl_sy_r <= 2'h3;
			sda_sy_r <= 2'h3;
			tin_sy_r <= 2'h0;
			scl_q_r  <= 1'b1;
			sda_q_r  <= 1'b1;
			tin_q_r  <= 1'b0;
		end else if (pclk_en) begin
			scl_sy_r <= {scl_sy_r[0], link.scl};
			sda_sy_r <= {sda_sy_r[0], link.sda};
			tin_sy_r <= {tin_sy_r[0], tamper_input};
			scl_q_r  <= scl_s;
			sda_q_r  <= sda_s;
			tin_q_r  <= tin_s;
		end
	end

	assign scl_s    = scl_sy_r[1];
	assign sda_s    = sda_sy_r[1];
	assign tin_s    = tin_sy_r[1];
	// Data edges count only while clock stayed high
	assign start_c  = scl_s & scl_q_r & sda_q_r & ~sda_s; // see RQ11
	assign stop_c   = scl_s & scl_q_r & ~sda_q_r & sda_s; // see RQ11
	assign scl_rise = scl_s & ~scl_q_r; // see RQ8
	assign scl_fall = ~scl_s & scl_q_r;

	// ***********************************************************
	// Byte engine
	// ***********************************************************
	dev_state_t  st_r;
	logic [2:0]  cnt_r;
	logic [7:0]  sh_r;
	logic [7:0]  tx_r;
	logic        done_r;
	logic        sel_ok_r;
	logic        rw_r;
	logic        tgt_rtc_r;
	logic [1:0]  idx_r;
	logic        acked_r;
	logic        sda_low_r;
	logic [7:0]  rx_byte;
	logic        rx_last;
	logic        in_rx;
	logic        mem_we;
	logic        hi_ld;
	logic        lo_ld;
	logic        ptr_ld;
	logic        rtc_we;
	logic        tx_load;
	logic [7:0]  tx_val;
	logic        addr_match;
	logic        rtc_hit;

	logic [MEM_AW-1:0] mem_addr_r;
	logic [3:0]        ptr_r;
	logic [7:0]        mem [0:MEM_DEPTH-1];
	wire  logic [7:0]  rtc_q [0:RTC_REGS-1];

	assign rx_byte = {sh_r[6:0], sda_s};
	assign rx_last = scl_rise & (cnt_r == 3'h7);
	assign in_rx   = (st_r == D_RX);
	// Commit on the eighth bit, well ahead of the ack slot
	assign mem_we  = in_rx & rx_last & ~tgt_rtc_r & (idx_r == 2'h2); // see RQ22
	assign hi_ld   = in_rx & rx_last & ~tgt_rtc_r & (idx_r == 2'h0); // see RQ16
	assign lo_ld   = in_rx & rx_last & ~tgt_rtc_r & (idx_r == 2'h1); // see RQ16
	assign ptr_ld  = in_rx & rx_last & tgt_rtc_r & (idx_r == 2'h0); // see RQ20
	assign rtc_we  = in_rx & rx_last & tgt_rtc_r & (idx_r != 2'h0);
	assign tx_load = scl_fall & (((st_r == D_ACK) & rw_r)
		| ((st_r == D_TXACK) & acked_r)); // see RQ13
	assign rtc_hit = (ptr_r <= RTC_LAST_REG);
	assign tx_val  = tgt_rtc_r ? (rtc_hit ? rtc_q[ptr_r] : 8'h00)
		: mem[mem_addr_r]; // see RQ17
	assign addr_match = ((rx_byte[7:4] == MEM_TYPE_ID)
		| (rx_byte[7:4] == RTC_TYPE_ID))
		& (rx_byte[3:1] == chip_select_pins); // see RQ14

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r      <= D_IDLE;
			cnt_r     <= 3'h0;
			sh_r      <= 8'h00;
			tx_r      <= 8'h00;
			done_r    <= 1'b0;
			sel_ok_r  <= 1'b0;
			rw_r      <= 1'b0;
			tgt_rtc_r <= 1'b0;
			idx_r     <= 2'h0;
			acked_r   <= 1'b0;
			sda_low_r <= 1'b0;
		end else if (pclk_en) begin
			if (start_c) begin
				st_r      <= D_ADDR; // see RQ9
				cnt_r     <= 3'h0;
				done_r    <= 1'b0;
				sda_low_r <= 1'b0;
			end else if (stop_c) begin
				st_r      <= D_IDLE; // see RQ10
				sda_low_r <= 1'b0;
			end else begin
				case (st_r)
				D_ADDR, D_RX: begin
					if (scl_rise) begin
						sh_r  <= rx_byte;
						cnt_r <= cnt_r + 3'h1;
					end
					if (rx_last) begin
						done_r <= 1'b1;
						if (st_r == D_ADDR) begin
							sel_ok_r  <= addr_match;
							rw_r      <= rx_byte[0];
							tgt_rtc_r <= (rx_byte[7:4] == RTC_TYPE_ID); // see RQ15
							idx_r     <= 2'h0;
						end else if (idx_r != 2'h2) begin
							// Saturates: any number of data bytes
							idx_r <= idx_r + 2'h1; // see RQ19
						end
					end
					if (scl_fall && done_r) begin
						done_r <= 1'b0;
						if (st_r == D_RX || sel_ok_r) begin
							st_r      <= D_ACK; // see RQ12
							sda_low_r <= 1'b1;
						end else begin
							st_r <= D_IDLE; // see RQ24
						end
					end
				end
				D_ACK: begin
					if (scl_fall) begin
						cnt_r <= 3'h0;
						if (rw_r) begin
							st_r      <= D_TX;
							tx_r      <= tx_val;
							sda_low_r <= ~tx_val[7];
						end else begin
							st_r      <= D_RX;
							sda_low_r <= 1'b0;
						end
					end
				end
				D_TX: begin
					if (scl_rise) begin
						cnt_r <= cnt_r + 3'h1;
						if (cnt_r == 3'h7)
							done_r <= 1'b1;
					end
					if (scl_fall) begin
						if (done_r) begin
							// Release so the master can answer
							done_r    <= 1'b0;
							sda_low_r <= 1'b0; // see RQ12
							st_r      <= D_TXACK;
						end else begin
							sda_low_r <= ~tx_r[6];
							tx_r      <= {tx_r[6:0], 1'b0};
						end
					end
				end
				D_TXACK: begin
					if (scl_rise)
						acked_r <= ~sda_s;
					if (scl_fall) begin
						cnt_r <= 3'h0;
						if (acked_r) begin
							st_r      <= D_TX; // see RQ13
							tx_r      <= tx_val;
							sda_low_r <= ~tx_val[7];
						end else begin
							st_r <= D_IDLE; // see RQ12
						end
					end
				end
				default: begin
					st_r      <= D_IDLE;
					sda_low_r <= 1'b0;
				end
				endcase
			end
		end
	end

	assign link.dev_sda_o  = 1'b0;
	assign link.dev_sda_oe = sda_low_r;

	// ***********************************************************
	// Address latches, kept across transactions
	// ***********************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_addr_r <= 15'h0000;
		end else if (pclk_en) begin
			if (hi_ld)
				mem_addr_r[14:8] <= rx_byte[6:0]; // see RQ16
			else if (lo_ld)
				mem_addr_r[7:0] <= rx_byte; // see RQ23
			else if ((mem_we | tx_load) & ~tgt_rtc_r)
				mem_addr_r <= mem_addr_r + 15'h0001; // see RQ18
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ptr_r <= 4'h0;
		end else if (pclk_en) begin
			if (ptr_ld)
				ptr_r <= rx_byte[3:0]; // see RQ20
			else if ((rtc_we | tx_load) & tgt_rtc_r)
				ptr_r <= ptr_r + 4'h1; // see RQ17
		end
	end

	// Array holds no reset: contents are not control state
	always_ff @(posedge pclk) begin
		if (pclk_en && mem_we)
			mem[mem_addr_r] <= rx_byte; // see RQ15
	end

	// ***********************************************************
	// Clock/tamper registers
	// ***********************************************************
	logic tamper_rise;

	// Edge is masked while the flag is still standing
	assign tamper_rise = tin_s & ~tin_q_r & ~tamper_flag; // see RQ2

	genvar i;
	generate
		for (i = 0; i < RTC_REGS; i++) begin : g_rtc
			localparam int unsigned TI = (i >= TS_FIRST_REG)
				? (i - TS_FIRST_REG) : 0;
			logic [7:0] q_r;
			logic       wr;
			logic       cap;
			assign wr  = rtc_we & (ptr_r == 4'(i));
			assign cap = (i >= TS_FIRST_REG) & tamper_rise
				& timestamp_capture_enable; // see RQ6
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					q_r <= RTC_RESET; // see RQ4
				end else if (pclk_en) begin
					if (cap)
						q_r <= current_time[8*TI +: 8]; // see RQ6
					else if (wr && i == REG_CTRL)
						// Software may clear the flag, never set it
						q_r <= {q_r[FLAG_BIT] & rx_byte[FLAG_BIT],
							rx_byte[6:0]}; // see RQ3
					else if (wr)
						q_r <= rx_byte; // see RQ5
					// A same-cycle clear wins, as the edge is masked by the flag
					if (i == REG_CTRL && tamper_rise)
						q_r[FLAG_BIT] <= 1'b1; // see RQ1
				end
			end
			assign rtc_q[i] = q_r;
		end
	endgenerate

	assign tamper_flag              = rtc_q[REG_CTRL][FLAG_BIT];
	assign timestamp_capture_enable = rtc_q[REG_CAL][TIMESTAMP_CAPTURE_ENABLE_BIT]; // see RQ5

endmodule // twowire_dev_end

// file: inc/twowire_pkg.sv
// Shared constants and types for the two-wire slave and its master end.
// Assumes a 25 MHz pclk on both ends and an APB master on the host side.
//
// Operation
// RQ1: tamper rising edge sets control register flag
// RQ2: set flag ignores tamper input until cleared
// RQ3: host software reads and clears the flag
// RQ4: flag is zero after power-up reset
// RQ5: timestamp enable is register 1 bit 6
// RQ6: enabled tamper edge loads time into registers
// RQ7: host reads flag, then time, before hold
// RQ8: device is slave; master makes serial clock
// RQ9: start anywhere aborts and awaits slave address
// RQ10: master ends with stop; stop aborts operation
// RQ11: data changes while clock low, sampled high
// RQ12: receiver acknowledges ninth bit; missing ack aborts
// RQ13: device keeps sending while master acknowledges
// RQ14: address byte holds type, select, direction
// RQ15: two type codes; clock target spares memory
// RQ16: memory address two bytes, fifteen bits used
// RQ17: separate address latches kept across transactions
// RQ18: memory address increments, wraps to zero
// RQ19: no limit on bytes per transaction
// RQ20: clock address low nibble selects register
// RQ21: master never loads clock addresses nine up
// RQ22: memory write commits after eighth data bit
// RQ23: address write then repeated start reads there
// RQ24: mismatched address ignored until next start
package twowire_pkg;

	// ***********************************************************
	// Timing
	// ***********************************************************
	localparam int unsigned PCLK_HZ      = 25_000_000;
	localparam int unsigned SCL_PHASE_NS = 80;
	// Least time, rounded up to whole pclk cycles
	localparam int unsigned PHASE_CYC =
		(SCL_PHASE_NS * (PCLK_HZ / 1_000_000) + 999) / 1000;
	localparam logic [3:0]  PHASE_LAST   = 4'(PHASE_CYC - 1);

	// ***********************************************************
	// Slave address and register file
	// ***********************************************************
	// Type codes are arbitrary values
	localparam logic [3:0]  MEM_TYPE_ID  = 4'h5;
	localparam logic [3:0]  RTC_TYPE_ID  = 4'h3;
	localparam int unsigned MEM_AW       = 15;
	localparam int unsigned MEM_DEPTH    = 32768;
	localparam int unsigned RTC_REGS     = 9;
	localparam logic [3:0]  RTC_LAST_REG = 4'h8;
	localparam int unsigned REG_CTRL     = 0;
	localparam int unsigned REG_CAL      = 1;
	localparam int unsigned TS_FIRST_REG = 2;
	localparam int unsigned TIME_W       = 56;
	localparam int unsigned FLAG_BIT     = 7;
	localparam int unsigned TIMESTAMP_CAPTURE_ENABLE_BIT     = 6;
	localparam logic [7:0]  RTC_RESET    = 8'h00;

	// ***********************************************************
	// Host APB registers
	// ***********************************************************
	localparam logic [7:0]  CMD_OFS      = 8'h00;
	localparam logic [7:0]  STAT_OFS     = 8'h04;
	localparam int unsigned CMD_DATA_LSB = 8;
	localparam int unsigned CMD_ACK_BIT  = 16;
	localparam int unsigned ST_BUSY_BIT  = 0;
	localparam int unsigned ST_ACK_BIT   = 1;
	localparam int unsigned ST_DATA_LSB  = 8;
	localparam logic [2:0]  OP_START     = 3'h1;
	localparam logic [2:0]  OP_STOP      = 3'h2;
	localparam logic [2:0]  OP_WRITE     = 3'h3;
	localparam logic [2:0]  OP_READ      = 3'h4;

	typedef enum logic [5:0] {
		D_IDLE  = 6'b000001,
		D_ADDR  = 6'b000010,
		D_ACK   = 6'b000100,
		D_RX    = 6'b001000,
		D_TX    = 6'b010000,
		D_TXACK = 6'b100000
	} dev_state_t;

	typedef enum logic [3:0] {
		H_IDLE  = 4'b0001,
		H_START = 4'b0010,
		H_STOP  = 4'b0100,
		H_XFER  = 4'b1000
	} host_state_t;

endpackage

// file: inc/twowire_if.sv
// Two-wire link between the master end and the slave end.
// Resolves the open-drain data line from both enables; clock is push-pull.
`timescale 1ns/1ps
interface twowire_if;
	logic scl;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic sda;

	// Pulled high unless an end drives low
	assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

	modport host (output scl, output host_sda_o, output host_sda_oe,
		input sda);
	modport device (input scl, input sda, output dev_sda_o,
		output dev_sda_oe);
endinterface

// file: rtl/twowire_host_end.sv
// Master end: APB-programmed byte sequencer driving the two-wire link.
// Assumes software issues start, bytes and stop in legal order.
`timescale 1ns/1ps
module twowire_host_end (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        pclk_en,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	twowire_if.host          link
);
	import twowire_pkg::*;

	// ***********************************************************
	// APB slave
	// ***********************************************************
	host_state_t st_r;
	logic        pready_r;
	logic [31:0] prdata_r;
	logic [7:0]  rx_r;
	logic        ack_seen_r;
	logic        busy;
	logic        cmd_go;
	logic [2:0]  op;
	logic [31:0] status;

	assign busy   = (st_r != H_IDLE);
	assign op     = pwdata[2:0];
	// Commands arriving while busy are dropped
	assign cmd_go = psel & penable & pready_r & pwrite
		& (paddr == CMD_OFS) & ~busy;
	always_comb begin
		status                  = 32'h0000_0000;
		status[ST_BUSY_BIT]     = busy;
		status[ST_ACK_BIT]      = ack_seen_r;
		status[ST_DATA_LSB +: 8] = rx_r;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end else if (pclk_en) begin
			pready_r <= psel & ~penable;
			if (psel && !penable)
				prdata_r <= (paddr == STAT_OFS) ? status : 32'h0000_0000;
		end
	end

	assign pready  = pready_r;
	assign prdata  = prdata_r;
	assign pslverr = 1'b0;

	// ***********************************************************
	// Bit sequencer
	// ***********************************************************
	logic [1:0] sda_sy_r;
	logic       sda_s;
	logic [3:0] tick_r;
	logic       tick;
	logic [1:0] ph_r;
	logic [3:0] bit_r;
	logic [8:0] tx_r;
	logic       scl_r;
	logic       low_r;
	logic       is_start;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			sda_sy_r <= 2'h3;
		else if (pclk_en)
			sda_sy_r <= {sda_sy_r[0], link.sda};
	end
	assign sda_s    = sda_sy_r[1];
	assign tick     = (tick_r == PHASE_LAST);
	assign is_start = (st_r == H_START);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			tick_r <= 4'h0;
		else if (pclk_en)
			tick_r <= (!busy || tick) ? 4'h0 : tick_r + 4'h1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r       <= H_IDLE;
			ph_r       <= 2'h0;
			bit_r      <= 4'h0;
			tx_r       <= 9'h1FF;
			scl_r      <= 1'b1;
			low_r      <= 1'b0;
			rx_r       <= 8'h00;
			ack_seen_r <= 1'b0;
		end else if (pclk_en) begin
			case (st_r)
			H_IDLE: begin
				ph_r  <= 2'h0;
				bit_r <= 4'h0;
				if (cmd_go) begin
					case (op)
					OP_START: begin
						st_r  <= H_START;
						low_r <= 1'b0;
					end
					OP_STOP: begin
						st_r  <= H_STOP;
						low_r <= 1'b1;
					end
					OP_WRITE: begin
						st_r  <= H_XFER;
						tx_r  <= {pwdata[CMD_DATA_LSB +: 8], 1'b1};
						low_r <= ~pwdata[CMD_DATA_LSB + 7]; // see RQ11
					end
					OP_READ: begin
						// Ack only if software asked; last byte gets none
						st_r  <= H_XFER;
						tx_r  <= {8'hFF, ~pwdata[CMD_ACK_BIT]}; // see RQ13
						low_r <= 1'b0;
					end
					default: st_r <= H_IDLE;
					endcase
				end
			end
			H_START, H_STOP: begin
				if (tick) begin
					ph_r <= ph_r + 2'h1;
					case (ph_r)
					2'h0: scl_r <= 1'b1;
					2'h1: low_r <= is_start; // see RQ9
					2'h2: scl_r <= ~is_start; // see RQ10
					default: st_r <= H_IDLE;
					endcase
				end
			end
			H_XFER: begin
				if (tick) begin
					ph_r <= ph_r + 2'h1;
					case (ph_r)
					2'h0: scl_r <= 1'b1; // see RQ8
					2'h1: begin
						if (bit_r == 4'h8)
							ack_seen_r <= ~sda_s; // see RQ12
						else
							rx_r <= {rx_r[6:0], sda_s};
					end
					2'h2: scl_r <= 1'b0;
					default: begin
						if (bit_r == 4'h8) begin
							st_r <= H_IDLE;
						end else begin
							bit_r <= bit_r + 4'h1;
							tx_r  <= {tx_r[7:0], 1'b1};
							low_r <= ~tx_r[7];
						end
					end
					endcase
				end
			end
			default: st_r <= H_IDLE;
			endcase
		end
	end

	assign link.scl         = scl_r;
	assign link.host_sda_o  = 1'b0;
	assign link.host_sda_oe = low_r;

endmodule // twowire_host_end

// file: sim/twowire_asserts.sv
// Checker on the two-wire link and the tamper outputs of the slave end.
// Assumes it sits beside the link and shares the pclk domain.
`timescale 1ns/1ps
module twowire_asserts (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic scl,
	input wire logic sda,
	input wire logic dev_sda_oe,
	input wire logic tamper_input,
	input wire logic tamper_flag,
	input wire logic timestamp_capture_enable
);
	// ***********************************************************
	// Link and tamper properties
	// ***********************************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_dev_scl_low; $changed(dev_sda_oe) |-> !scl; endproperty
	a_dev_scl_low: assert property (p_dev_scl_low)
		else $error("device moved sda while scl high");

	property p_dev_hold; $rose(dev_sda_oe) |-> dev_sda_oe[*5]; endproperty
	a_dev_hold: assert property (p_dev_hold)
		else $error("device released sda too early");

	property p_scl_high; $rose(scl) |-> scl[*4]; endproperty
	a_scl_high: assert property (p_scl_high)
		else $error("scl high phase too short");

	property p_start_low;
		$fell(sda) && scl && $past(scl) |-> ##[1:4] !scl;
	endproperty
	a_start_low: assert property (p_start_low)
		else $error("no clock after start");

	property p_stop_idle;
		$rose(sda) && scl && $past(scl) |-> scl[*6];
	endproperty
	a_stop_idle: assert property (p_stop_idle)
		else $error("clock moved after stop");

	// Sync delay of the tamper pin is two flops plus the flag register
	property p_flag_set;
		$rose(tamper_input) && !tamper_flag |-> ##[1:5] tamper_flag;
	endproperty
	a_flag_set: assert property (p_flag_set)
		else $error("tamper edge not flagged");

	property p_flag_cause; $rose(tamper_flag) |-> $past(tamper_input, 2);
	endproperty
	a_flag_cause: assert property (p_flag_cause)
		else $error("flag set without tamper edge");

	// Only a host write, committed with scl high, may clear the flag
	property p_flag_clear; $fell(tamper_flag) |-> scl || $past(scl);
	endproperty
	a_flag_clear: assert property (p_flag_clear)
		else $error("flag cleared without host write");

	property p_timestamp_capture_enable_host;
		$changed(timestamp_capture_enable) |-> scl || $past(scl);
	endproperty
	a_timestamp_capture_enable_host: assert property (p_timestamp_capture_enable_host)
		else $error("timestamp enable moved without host write");
endmodule // twowire_asserts

// file: sim/tb.sv
// Bench joining the host end to the device end over one link.
// Assumes the package constants; a model tracks memory and clock regs.
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
	n_mismatch++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb;
	import twowire_pkg::*;
	// ***********************************************************
	// Signals, model state and instances
	// ***********************************************************
	logic              pclk = 1'b0;
	logic              presetn = 1'b0;
	logic              psel = 1'b0;
	logic              penable = 1'b0;
	logic              pwrite = 1'b0;
	logic [7:0]        paddr = 8'h00;
	logic [31:0]       pwdata = 32'h0;
	logic [31:0]       prdata;
	logic              pready;
	logic [2:0]        cs = 3'h5;
	logic              tamper_input = 1'b0;
	logic [TIME_W-1:0] current_time = '0;
	logic              tamper_flag;
	logic              timestamp_capture_enable;
	logic [31:0]       lfsr = 32'hA29F;
	logic [31:0]       st;
	logic [7:0]        bad [3];
	logic [7:0]        mem [int];
	logic [7:0]        rr [9] = '{default: RTC_RESET};
	int                mlat = 0;
	int                rptr = 0;
	int                n_mismatch = 0;
	int                comparisons = 0;

	twowire_if link();
	twowire_host_end i_twowire_host_end (.pclk(pclk), .presetn(presetn),
		.pclk_en(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(), .link(link));
	twowire_dev_end i_twowire_dev_end (.pclk(pclk), .presetn(presetn),
		.pclk_en(1'b1), .link(link), .chip_select_pins(cs),
		.tamper_input(tamper_input), .current_time(current_time),
		.tamper_flag(tamper_flag),
		.timestamp_capture_enable(timestamp_capture_enable));
	twowire_asserts i_twowire_asserts (.pclk(pclk), .presetn(presetn),
		.scl(link.scl), .sda(link.sda), .dev_sda_oe(link.dev_sda_oe),
		.tamper_input(tamper_input), .tamper_flag(tamper_flag),
		.timestamp_capture_enable(timestamp_capture_enable));

	always #20 pclk = ~pclk;

	// ***********************************************************
	// Bus tasks and model
	// ***********************************************************
	function automatic void step();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
	endfunction

	// Starts one edge late so psel never gets two writes in one step
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// No assumed latency: only the watchdog ends a stuck access
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic op(input logic [2:0] o, input logic [7:0] b,
		input logic ak, output logic [31:0] s);
		logic [31:0] q;
		apb(1'b1, CMD_OFS, {15'h0, ak, b, 5'h0, o}, q);
		do begin
			apb(1'b0, STAT_OFS, 32'h0, s);
		end while (s[ST_BUSY_BIT] !== 1'b0);
	endtask

	task automatic wb(input logic [7:0] b, input logic ak);
		op(OP_WRITE, b, 1'b0, st);
		`CHK(st[ST_ACK_BIT], ak)
	endtask

	task automatic go(input logic [7:0] b);
		op(OP_START, 8'h00, 1'b0, st);
		wb(b, 1'b1);
	endtask

	task automatic stp();
		op(OP_STOP, 8'h00, 1'b0, st);
	endtask

	task automatic rd(input logic [3:0] ty, input int n);
		logic [7:0] e;
		go({ty, cs, 1'b1});
		for (int i = 0; i < n; i++) begin
			op(OP_READ, 8'h00, i < n - 1, st);
			if (ty == MEM_TYPE_ID) begin
				e = mem[mlat];
				mlat = (mlat + 1) & 32'h7FFF;
			end else begin
				e = (rptr < RTC_REGS) ? rr[rptr] : 8'h00;
				rptr = (rptr + 1) & 15;
			end
			`CHK(st[ST_DATA_LSB +: 8], e)
		end
		stp();
	endtask

	task automatic mem_set(input logic [15:0] a);
		go({MEM_TYPE_ID, cs, 1'b0});
		wb(a[15:8], 1'b1);
		wb(a[7:0], 1'b1);
		mlat = int'(a[14:0]);
	endtask

	task automatic mem_wr(input int n);
		for (int i = 0; i < n; i++) begin
			step();
			wb(lfsr[7:0], 1'b1);
			mem[mlat] = lfsr[7:0];
			mlat = (mlat + 1) & 32'h7FFF;
		end
		stp();
	endtask

	task automatic rtc_ptr(input logic [7:0] p);
		go({RTC_TYPE_ID, cs, 1'b0});
		wb(p, 1'b1);
		rptr = int'(p[3:0]);
	endtask

	task automatic rtc_wr(input logic [7:0] p, input logic [7:0] d);
		rtc_ptr(p);
		wb(d, 1'b1);
		rr[rptr] = d;
		rptr = (rptr + 1) & 15;
		stp();
	endtask

	// Pin held for 12 cycles, well past the sync and capture delay
	task automatic tamp();
		logic [TIME_W-1:0] t;
		step();
		t = {lfsr[23:0], lfsr};
		current_time <= t;
		tamper_input <= 1'b1;
		if (rr[0][FLAG_BIT] === 1'b0) begin
			rr[0][FLAG_BIT] = 1'b1;
			if (rr[1][TIMESTAMP_CAPTURE_ENABLE_BIT]) for (int k = 0; k < 7; k++) begin
				rr[TS_FIRST_REG + k] = t[8 * k +: 8];
			end
		end
		repeat (12) @(posedge pclk);
		`CHK(tamper_flag, 1'b1)
		tamper_input <= 1'b0;
		repeat (12) @(posedge pclk);
	endtask

	task automatic wrap_up();
		if (n_mismatch == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// ***********************************************************
	// Scenarios and watchdog
	// ***********************************************************
	initial begin
		step();
		cs <= lfsr[2:0];
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		`CHK(tamper_flag, 1'b0)
		`CHK(timestamp_capture_enable, 1'b0)
		rtc_ptr(8'h00);
		rd(RTC_TYPE_ID, 9);
		mem_set(16'hFFFE);
		mem_wr(5);
		mem_set(16'h7FFE);
		rd(MEM_TYPE_ID, 4);
		rtc_wr(8'hF1, 8'h40);
		`CHK(timestamp_capture_enable, 1'b1)
		rd(MEM_TYPE_ID, 1);
		tamp();
		tamp();
		rtc_ptr(8'h30);
		rd(RTC_TYPE_ID, 9);
		rtc_wr(8'h00, 8'h00);
		`CHK(tamper_flag, 1'b0)
		rtc_wr(8'h01, 8'h00);
		tamp();
		rtc_ptr(8'h00);
		rd(RTC_TYPE_ID, 9);
		bad = '{{4'h9, cs, 1'b0}, {MEM_TYPE_ID, cs ^ 3'h1, 1'b0},
			{RTC_TYPE_ID, cs ^ 3'h4, 1'b1}};
		foreach (bad[i]) begin
			op(OP_START, 8'h00, 1'b0, st);
			op(OP_WRITE, bad[i], 1'b0, st);
			`CHK(st[ST_ACK_BIT], 1'b0)
			op(OP_WRITE, lfsr[7:0], 1'b0, st);
			`CHK(st[ST_ACK_BIT], 1'b0)
			stp();
		end
		mem_set(16'h7FFE);
		rd(MEM_TYPE_ID, 5);
		wrap_up();
	end

	initial begin
		repeat (40000) @(posedge pclk);
		n_mismatch++;
		wrap_up();
	end
endmodule // tb
